// >>> prs_cfg.svh
// Constants of the power, reset and boot sequencer.
// Assumes a 250 MHz system clock; all times are turned into cycles here.
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

// System clock
`define PRS_CLK_MHZ 250
`define PRS_CLK_PS 4000

// Hold of internal resets after the sense input rises
`define PRS_HOLD_MS 100
`define PRS_HOLD_CYC (`PRS_HOLD_MS * `PRS_CLK_MHZ * 1000)

// Window in which the power-good warning is ignored
`define PRS_PG_IGN_MS 60
`define PRS_PG_IGN_CYC (`PRS_PG_IGN_MS * `PRS_CLK_MHZ * 1000)

// Flash wait-state resolution, rounded up to whole cycles
`define PRS_WS_NORM_PS 6700
`define PRS_WS_LP_PS 53570
`define PRS_WS_NORM_CYC ((`PRS_WS_NORM_PS + `PRS_CLK_PS - 1) / `PRS_CLK_PS)
`define PRS_WS_LP_CYC ((`PRS_WS_LP_PS + `PRS_CLK_PS - 1) / `PRS_CLK_PS)
`define PRS_WS_W 5

// Pin map and widths
`define PRS_INIT_PIN 26
`define PRS_GPIO_W 32
`define PRS_MIRROR_W 24
`define PRS_RST_OUT_W 4
`define PRS_RATE_W 4

// Memory test
`define PRS_MT_DEPTH 64
`define PRS_MT_DW 16
`define PRS_MT_SEED 16'ha5c3

`endif

// >>> prs_pkg.sv
// Types shared by the sequencer and its helpers.
// Assumes prs_cfg.svh for all numeric constants.
package prs_pkg;

  typedef enum logic [2:0] {
    ST_OFF   = 3'h0,
    ST_HOLD  = 3'h1,
    ST_BOOT  = 3'h2,
    ST_DCG   = 3'h3,
    ST_CLKS  = 3'h4,
    ST_MTEST = 3'h5,
    ST_READY = 3'h6,
    ST_PGRST = 3'h7
  } prs_state_t;

  typedef enum logic {
    FSEL_BOOT = 1'b0,
    FSEL_OPT  = 1'b1
  } prs_fsel_t;

endpackage

// >>> prs_if.sv
// Carriers between the sequencer and its memory and flash helpers.
// Assumes a single clock shared by both ends.
`timescale 1ns/100ps
`include "prs_cfg.svh"

interface prs_mem_if #(parameter int DW = 16, parameter int AW = 6);
  logic we;
  logic re;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctl (output we, re, addr, wdata, input rdata);
  modport mem (input we, re, addr, wdata, output rdata);
endinterface

interface prs_flash_if;
  logic req;
  logic abort;
  prs_pkg::prs_fsel_t sel;
  logic [`PRS_WS_W-1:0] wait_st;
  logic low_pwr;
  logic ack;
  logic [1:0] cs_n;
  modport ctl (output req, abort, sel, wait_st, low_pwr, input ack, cs_n);
  modport eng (input req, abort, sel, wait_st, low_pwr, output ack, cs_n);
endinterface

// >>> prs_mem.sv
// Small test memory with registered read data.
// Assumes one access per cycle from the sequencer's memory test.
`timescale 1ns/100ps

module prs_mem #(
  parameter int DW = 16,
  parameter int DEPTH = 64
) (
  // Clock
  input wire logic clk_i,
  // Access port
  prs_mem_if.mem m
);
  import prs_pkg::*;

  logic [DW-1:0] mem_reg [DEPTH];
  logic [DW-1:0] rdata_reg;

  // No reset on the array: its content is what the test probes
  always_ff @(posedge clk_i) begin
    if (m.we) begin
      mem_reg[m.addr] <= m.wdata;
    end
    if (m.re) begin
      rdata_reg <= mem_reg[m.addr];
    end
  end

  assign m.rdata = rdata_reg;

endmodule // prs_mem

// >>> prs_flash.sv
// Program-flash access timer: chip selects and wait-state counting.
// Assumes the sequencer only requests while the processor runs.
`timescale 1ns/100ps
`include "prs_cfg.svh"

module prs_flash #(
  parameter int WS_NORM = `PRS_WS_NORM_CYC,
  parameter int WS_LP = `PRS_WS_LP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Request side
  prs_flash_if.eng f
);
  import prs_pkg::*;

  localparam int SW = 4;

  typedef struct packed {
    logic busy;
    logic ack;
    logic [1:0] cs_n;
    logic [`PRS_WS_W-1:0] ws;
    logic [SW-1:0] sub;
  } prs_fl_t;

  prs_fl_t state_reg;
  prs_fl_t state_next;
  logic [SW-1:0] step_m1;

  if (WS_NORM < 1 || WS_LP < 1 || WS_LP > (1 << SW) || WS_NORM > (1 << SW)) begin : g_chk
    $error("prs_flash: wait-state step out of range");
  end

  always_comb begin
    step_m1 = f.low_pwr ? SW'(WS_LP - 1) : SW'(WS_NORM - 1);
    state_next = state_reg;
    state_next.ack = 1'b0;
    if (f.abort) begin
      state_next.busy = 1'b0;
      state_next.cs_n = 2'b11;
    end else if (!state_reg.busy) begin
      if (f.req) begin
        state_next.busy = 1'b1;
        state_next.ws = f.wait_st;
        state_next.sub = step_m1;
        state_next.cs_n = (f.sel == FSEL_OPT) ? 2'b01 : 2'b10;
      end
    end else if (state_reg.sub != '0) begin
      state_next.sub = state_reg.sub - 1'b1;
    end else if (state_reg.ws != '0) begin
      state_next.ws = state_reg.ws - 1'b1;
      state_next.sub = step_m1;
    end else begin
      state_next.busy = 1'b0;
      state_next.ack = 1'b1;
      state_next.cs_n = 2'b11;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= '{busy: 1'b0, ack: 1'b0, cs_n: 2'b11, ws: '0, sub: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign f.ack = state_reg.ack;
  assign f.cs_n = state_reg.cs_n;

endmodule // prs_flash

// >>> prs_sequencer.sv
// Power-up, system reset and boot sequencer of the controller.
// Assumes an external power monitor drives the sense and warning pins.
//
// Functional notes
// - Sense rise frees master PLL, holds rest.
// - Sense low keeps outputs low or floating, except DCG and mirror rates, which hold.
// - Power-good warning ignored 60 ms after sense.
// - Every system reset restores full-power mode.
// - Every system reset floats all general pins.
// - Master PLL reset only by power-up.
// - Processor clocks run full rate after reset.
// - Mirror PLL powered down, dividers in reset.
// - Mirror outputs low, drive enable floating.
// - Reset outputs held until processor frees them.
// - DCG rate and PLL enable, lock, mirror rate, then dividers freed.
// - Memory test then init-complete on pin 26.
// - Flash wait states up to 31, two resolutions.
// - Two flash chip selects, boot and optional.
// - Two pins become flash address 21, 22.
// - Two-way pins are inputs out of reset.
`timescale 1ns/100ps
`include "prs_cfg.svh"

module prs_sequencer #(
  parameter int HOLD_CYC = `PRS_HOLD_CYC,
  parameter int PG_CYC = `PRS_PG_IGN_CYC,
  parameter int GW = `PRS_GPIO_W,
  parameter int MW = `PRS_MIRROR_W,
  parameter int RN = `PRS_RST_OUT_W,
  parameter int RW = `PRS_RATE_W,
  parameter int MT_DEPTH = `PRS_MT_DEPTH,
  parameter int MT_DW = `PRS_MT_DW
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Power monitor pins
  input wire logic power_on_sense_i,
  input wire logic power_good_warning_i,
  // Master PLL
  output logic master_pll_rst_n_o,
  // Mirror DDR PLL and clock generator
  input wire logic mirror_ddr_pll_lock_i,
  output logic mirror_ddr_pll_en_o,
  output logic mirror_ddr_pll_div_rst_n_o,
  output logic [RW-1:0] ddr_clock_generator_rate_o,
  output logic [RW-1:0] mirror_clk_rate_o,
  // Processor side
  output logic cpu_rst_n_o,
  output logic cpu_clk_full_o,
  output logic normal_mode_o,
  output logic mirror_park_o,
  input wire logic boot_done_i,
  input wire logic low_power_req_i,
  input wire logic [RW-1:0] dcg_rate_i,
  input wire logic [RW-1:0] mirror_rate_i,
  input wire logic [RN-1:0] rst_release_i,
  input wire logic [MW-1:0] mirror_data_i,
  input wire logic mirror_oe_i,
  input wire logic [GW-1:0] gpio_out_i,
  input wire logic [GW-1:0] gpio_dir_i,
  output logic [GW-1:0] gpio_rd_o,
  output logic memtest_fail_o,
  // Flash requests
  input wire logic fl_req_i,
  input wire logic fl_sel_i,
  input wire logic [`PRS_WS_W-1:0] fl_wait_i,
  input wire logic [1:0] fl_addr_hi_i,
  input wire logic [1:0] addr_pin_en_i,
  output logic fl_ack_o,
  output logic [1:0] addr_pin_rd_o,
  // Reset outputs
  output logic [RN-1:0] rst_out_n_o,
  // Mirror interface
  output logic [MW-1:0] mirror_data_o,
  output logic mirror_drive_output_enable_o,
  output logic mirror_drive_output_enable_oe_o,
  // General pins
  input wire logic [GW-1:0] gpio_i,
  output logic [GW-1:0] gpio_o,
  output logic [GW-1:0] gpio_oe_o,
  // Flash pins
  output logic boot_flash_select_n_o,
  output logic optional_flash_select_n_o,
  output logic flash_select_oe_o,
  input wire logic flash_addr_bit21_pin_i,
  output logic flash_addr_bit21_pin_o,
  output logic flash_addr_bit21_pin_oe_o,
  input wire logic flash_addr_bit22_pin_i,
  output logic flash_addr_bit22_pin_o,
  output logic flash_addr_bit22_pin_oe_o
);
  import prs_pkg::*;

  localparam int CW = $clog2((HOLD_CYC > PG_CYC ? HOLD_CYC : PG_CYC) + 1);
  localparam int AW = $clog2(MT_DEPTH);
  localparam int PW = GW + 2;
  localparam logic [AW-1:0] MT_LAST = AW'(MT_DEPTH - 1);

  if (GW <= `PRS_INIT_PIN || HOLD_CYC < 1 || PG_CYC < 1 || MT_DEPTH < 2) begin : g_chk
    $error("prs_sequencer: parameter out of range");
  end

  typedef struct packed {
    logic [1:0] pos_s;
    logic [1:0] pg_s;
    logic [1:0] lock_s;
    logic [PW-1:0] pin_s1;
    logic [PW-1:0] pin_s2;
    prs_state_t st;
    logic [CW-1:0] cnt;
    logic [CW-1:0] pg_cnt;
    logic low_pwr;
    logic pll_en;
    logic div_rel;
    logic [RW-1:0] dcg_rate;
    logic [RW-1:0] mir_rate;
    logic [RN-1:0] rst_rel;
    logic [MW-1:0] mdata;
    logic moe;
    logic [GW-1:0] gp_out;
    logic [GW-1:0] gp_oe;
    logic [1:0] addr_en;
    logic [1:0] addr_hi;
    logic mt_rd;
    logic mt_all;
    logic mt_pend;
    logic [AW-1:0] mt_addr;
    logic [AW-1:0] mt_chk;
    logic fail;
    logic init_done;
  } prs_seq_t;

  prs_seq_t state_reg;
  prs_seq_t state_next;
  logic pos;
  logic running;
  logic pg_fault;
  logic mismatch;

  prs_mem_if #(.DW(MT_DW), .AW(AW)) mi ();
  prs_flash_if fi ();

  function automatic logic [MT_DW-1:0] prs_pat(input logic [AW-1:0] a);
    prs_pat = MT_DW'(a) ^ MT_DW'(`PRS_MT_SEED) ^ MT_DW'({a, 1'b0});
  endfunction

  assign pos = state_reg.pos_s[1];
  assign running = state_reg.st inside {ST_BOOT, ST_DCG, ST_CLKS, ST_MTEST, ST_READY};
  // Warning only counts once the ignore window has run out
  assign pg_fault = running && (state_reg.pg_cnt == CW'(PG_CYC)) && !state_reg.pg_s[1];
  assign mismatch = mi.rdata != prs_pat(state_reg.mt_chk);

  always_comb begin
    state_next = state_reg;
    state_next.pos_s = {state_reg.pos_s[0], power_on_sense_i};
    state_next.pg_s = {state_reg.pg_s[0], power_good_warning_i};
    state_next.lock_s = {state_reg.lock_s[0], mirror_ddr_pll_lock_i};
    state_next.pin_s1 = {flash_addr_bit22_pin_i, flash_addr_bit21_pin_i, gpio_i};
    state_next.pin_s2 = state_reg.pin_s1;
    if (!pos) begin
      state_next.pg_cnt = '0;
    end else if (state_reg.pg_cnt != CW'(PG_CYC)) begin
      state_next.pg_cnt = state_reg.pg_cnt + 1'b1;
    end
    if (running) begin
      state_next.gp_out = gpio_out_i;
      state_next.gp_oe = gpio_dir_i;
      state_next.addr_en = {addr_pin_en_i[1] & addr_pin_en_i[0], addr_pin_en_i[0]};
      state_next.addr_hi = fl_addr_hi_i;
      state_next.rst_rel = state_reg.rst_rel | rst_release_i;
    end
    unique case (state_reg.st)
      ST_OFF: begin
        state_next.cnt = '0;
        if (pos) begin
          state_next.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (state_reg.cnt == CW'(HOLD_CYC - 1)) begin
          state_next.st = ST_BOOT;
        end else begin
          state_next.cnt = state_reg.cnt + 1'b1;
        end
      end
      ST_BOOT: begin
        if (boot_done_i) begin
          state_next.dcg_rate = dcg_rate_i;
          state_next.pll_en = 1'b1;
          state_next.st = ST_DCG;
        end
      end
      ST_DCG: begin
        if (state_reg.lock_s[1]) begin
          state_next.mir_rate = mirror_rate_i;
          state_next.st = ST_CLKS;
        end
      end
      ST_CLKS: begin
        state_next.div_rel = 1'b1;
        state_next.mt_rd = 1'b0;
        state_next.mt_all = 1'b0;
        state_next.mt_pend = 1'b0;
        state_next.mt_addr = '0;
        state_next.st = ST_MTEST;
      end
      ST_MTEST: begin
        if (!state_reg.mt_rd) begin
          state_next.mt_addr = state_reg.mt_addr + 1'b1;
          if (state_reg.mt_addr == MT_LAST) begin
            state_next.mt_rd = 1'b1;
            state_next.mt_addr = '0;
          end
        end else begin
          state_next.mt_pend = !state_reg.mt_all;
          state_next.mt_chk = state_reg.mt_addr;
          if (!state_reg.mt_all) begin
            if (state_reg.mt_addr == MT_LAST) begin
              state_next.mt_all = 1'b1;
            end else begin
              state_next.mt_addr = state_reg.mt_addr + 1'b1;
            end
          end
          if (state_reg.mt_pend) begin
            state_next.fail = state_reg.fail | mismatch;
            if (state_reg.mt_chk == MT_LAST) begin
              state_next.init_done = !(state_reg.fail | mismatch);
              state_next.st = ST_READY;
            end
          end
        end
      end
      ST_READY: begin
        state_next.low_pwr = low_power_req_i;
        state_next.mdata = mirror_data_i;
        state_next.moe = mirror_oe_i;
      end
      ST_PGRST: begin
        if (state_reg.pg_s[1]) begin
          state_next.st = ST_BOOT;
        end
      end
    endcase
    // Any system reset lands every control except dcg_rate, mir_rate and addr_hi back on its boot default
    if (!pos || pg_fault) begin
      state_next.st = pos ? ST_PGRST : ST_OFF;
      state_next.low_pwr = 1'b0;
      state_next.pll_en = 1'b0;
      state_next.div_rel = 1'b0;
      state_next.rst_rel = '0;
      state_next.mdata = '0;
      state_next.moe = 1'b0;
      state_next.gp_out = '0;
      state_next.gp_oe = '0;
      state_next.addr_en = '0;
      state_next.fail = 1'b0;
      state_next.init_done = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Master PLL sees only the sense pin, so a warning reset leaves it locked
  assign master_pll_rst_n_o = state_reg.st != ST_OFF;
  assign cpu_rst_n_o = running;
  assign cpu_clk_full_o = running && !state_reg.low_pwr;
  assign normal_mode_o = running && !state_reg.low_pwr;
  assign mirror_park_o = state_reg.st == ST_PGRST;
  assign mirror_ddr_pll_en_o = state_reg.pll_en;
  assign mirror_ddr_pll_div_rst_n_o = state_reg.div_rel;
  assign ddr_clock_generator_rate_o = state_reg.dcg_rate;
  assign mirror_clk_rate_o = state_reg.mir_rate;
  assign rst_out_n_o = state_reg.rst_rel;
  assign mirror_data_o = state_reg.mdata;
  assign mirror_drive_output_enable_o = state_reg.moe;
  assign mirror_drive_output_enable_oe_o = state_reg.div_rel;
  assign memtest_fail_o = state_reg.fail;
  assign gpio_rd_o = state_reg.pin_s2[GW-1:0];
  assign addr_pin_rd_o = state_reg.pin_s2[PW-1:GW];

  // Init-complete owns its pin from the start of the memory test
  for (genvar i = 0; i < GW; i++) begin : g_gpio
    if (i == `PRS_INIT_PIN) begin : g_init
      assign gpio_o[i] = state_reg.init_done;
      assign gpio_oe_o[i] = state_reg.st inside {ST_MTEST, ST_READY};
    end else begin : g_gen
      assign gpio_o[i] = state_reg.gp_out[i];
      assign gpio_oe_o[i] = state_reg.gp_oe[i];
    end
  end

  assign flash_addr_bit21_pin_o = state_reg.addr_hi[0];
  assign flash_addr_bit21_pin_oe_o = state_reg.addr_en[0];
  assign flash_addr_bit22_pin_o = state_reg.addr_hi[1];
  assign flash_addr_bit22_pin_oe_o = state_reg.addr_en[1];

  // Memory test port
  assign mi.we = (state_reg.st == ST_MTEST) && !state_reg.mt_rd;
  assign mi.re = (state_reg.st == ST_MTEST) && state_reg.mt_rd && !state_reg.mt_all;
  assign mi.addr = state_reg.mt_addr;
  assign mi.wdata = prs_pat(state_reg.mt_addr);

  prs_mem #(.DW(MT_DW), .DEPTH(MT_DEPTH)) u_mem (
    .clk_i(clk_i),
    .m(mi.mem)
  );

  // Flash port; an access in flight is cut short by any system reset
  assign fi.req = fl_req_i && running;
  assign fi.abort = !running;
  assign fi.sel = prs_fsel_t'(fl_sel_i);
  assign fi.wait_st = fl_wait_i;
  assign fi.low_pwr = state_reg.low_pwr;
  assign fl_ack_o = fi.ack;
  assign boot_flash_select_n_o = fi.cs_n[0];
  assign optional_flash_select_n_o = fi.cs_n[1];
  assign flash_select_oe_o = running;

  prs_flash u_flash (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .f(fi.eng)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  hold_release_a: assert property (
    $rose(cpu_rst_n_o) && $past(state_reg.st) == ST_HOLD
      |-> $past(state_reg.cnt) == CW'(HOLD_CYC - 1))
    else $error("processor released before the hold ran out");

  off_quiet_a: assert property (
    state_reg.st == ST_OFF |-> gpio_oe_o == '0 && mirror_data_o == '0 && !flash_select_oe_o
      && !mirror_drive_output_enable_oe_o && !cpu_rst_n_o && rst_out_n_o == '0)
    else $error("output active while sense low");

  pg_window_a: assert property (
    $rose(state_reg.st == ST_PGRST) |-> $past(state_reg.pg_cnt) == CW'(PG_CYC))
    else $error("warning acted inside ignore window");

  full_rate_a: assert property (
    $rose(cpu_rst_n_o) |-> cpu_clk_full_o && normal_mode_o)
    else $error("boot not at full rate");

  gpio_float_a: assert property (
    $rose(cpu_rst_n_o) |-> gpio_oe_o == '0 && !flash_addr_bit21_pin_oe_o ##1 !gpio_oe_o[26])
    else $error("general pin driven after reset");

  pll_keep_a: assert property (
    state_reg.st == ST_PGRST && pos |-> master_pll_rst_n_o ##1 master_pll_rst_n_o)
    else $error("master PLL reset on warning reset");

  mirror_idle_a: assert property (
    state_reg.st inside {ST_HOLD, ST_BOOT, ST_PGRST} |-> !mirror_ddr_pll_en_o
      && !mirror_ddr_pll_div_rst_n_o && mirror_data_o == '0 && !mirror_drive_output_enable_oe_o)
    else $error("mirror side active after reset");

  rst_hold_a: assert property (
    $rose(rst_out_n_o[0]) |-> $past(rst_release_i[0]))
    else $error("reset output freed without release");

  div_order_a: assert property (
    $rose(mirror_ddr_pll_div_rst_n_o) |-> mirror_ddr_pll_en_o && $past(state_reg.lock_s[1], 2))
    else $error("dividers freed before lock");

  init_pin_a: assert property (
    gpio_o[26] |-> state_reg.st == ST_READY && !memtest_fail_o && gpio_oe_o[26])
    else $error("init-complete without a passed test");

endmodule // prs_sequencer

// >>> prs_pwr_mon.sv
// Power monitor model: drives the sense and warning pins.
// Assumes the bench calls its tasks; long times are scaled down.
`timescale 1ns/100ps

module prs_pwr_mon #(
  parameter int LOW_MIN = 125000,
  parameter int WARN_MIN = 1000
) (
  // Clock
  input wire logic clk_i,
  // Monitor pins
  output logic power_on_sense_o,
  output logic power_good_warning_o
);
  initial begin
    power_on_sense_o = 1'b0;
    power_good_warning_o = 1'b1;
  end

  // Supplies ramp first
  task automatic sense_up(input int ramp);
    repeat (ramp) @(posedge clk_i);
    power_on_sense_o <= 1'b1;
  endtask

  task automatic sense_drop();
    @(posedge clk_i);
    power_on_sense_o <= 1'b0;
    repeat (LOW_MIN) @(posedge clk_i);
  endtask

  task automatic warn(input int n);
    @(posedge clk_i);
    power_good_warning_o <= 1'b0;
    repeat ((n < WARN_MIN) ? WARN_MIN : n) @(posedge clk_i);
    power_good_warning_o <= 1'b1;
  endtask

  // Warning leads the loss of supplies
  task automatic power_off();
    @(posedge clk_i);
    power_good_warning_o <= 1'b0;
    repeat (LOW_MIN) @(posedge clk_i);
    sense_drop();
  endtask
endmodule // prs_pwr_mon

// >>> prs_sequencer_tb_top.sv
// Bench of the sequencer against a power monitor model.
// Assumes prs_cfg.svh; hold and ignore counts are scaled down.
`timescale 1ns/100ps
`include "prs_cfg.svh"

module prs_sequencer_tb_top;
  import prs_pkg::*;
  localparam int HOLD = 16;
  localparam int PG = 40;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic power_on_sense_i, power_good_warning_i;
  logic mirror_ddr_pll_lock_i = 1'b0, boot_done_i = 1'b0, low_power_req_i = 1'b0;
  logic mirror_oe_i = 1'b1, fl_req_i = 1'b0, fl_sel_i = 1'b0;
  logic [3:0] dcg_rate_i = 4'h0, mirror_rate_i = 4'h0, rst_release_i = 4'h0;
  logic [23:0] mirror_data_i = 24'h0;
  logic [31:0] gpio_out_i = 32'h0, gpio_dir_i = 32'h0, gpio_i = 32'h0;
  logic [4:0] fl_wait_i = 5'h0;
  logic [1:0] fl_addr_hi_i = 2'h0, addr_pin_en_i = 2'h0;
  logic flash_addr_bit21_pin_i, flash_addr_bit22_pin_i;
  logic master_pll_rst_n_o, mirror_ddr_pll_en_o, mirror_ddr_pll_div_rst_n_o, cpu_rst_n_o;
  logic cpu_clk_full_o, normal_mode_o, mirror_park_o, memtest_fail_o, fl_ack_o;
  logic mirror_drive_output_enable_o, mirror_drive_output_enable_oe_o;
  logic boot_flash_select_n_o, optional_flash_select_n_o, flash_select_oe_o;
  logic flash_addr_bit21_pin_o, flash_addr_bit21_pin_oe_o;
  logic flash_addr_bit22_pin_o, flash_addr_bit22_pin_oe_o;
  logic [3:0] ddr_clock_generator_rate_o, mirror_clk_rate_o, rst_out_n_o;
  logic [31:0] gpio_rd_o, gpio_o, gpio_oe_o;
  logic [23:0] mirror_data_o;
  logic [1:0] addr_pin_rd_o;
  logic [3:0] exp_rst;
  int n_mismatch = 0, tests_run = 0, seed = 79, n;

  always #2 clk_i = ~clk_i;

  // Board pull-downs on the two address pins
  assign flash_addr_bit21_pin_i = flash_addr_bit21_pin_oe_o ? flash_addr_bit21_pin_o : 1'b0;
  assign flash_addr_bit22_pin_i = flash_addr_bit22_pin_oe_o ? flash_addr_bit22_pin_o : 1'b0;

  prs_pwr_mon #(.LOW_MIN(8), .WARN_MIN(4)) mon_u (.clk_i(clk_i),
    .power_on_sense_o(power_on_sense_i), .power_good_warning_o(power_good_warning_i));

  prs_sequencer #(.HOLD_CYC(HOLD), .PG_CYC(PG)) dut_u (.clk_i, .nrst_i, .power_on_sense_i,
    .power_good_warning_i, .master_pll_rst_n_o, .mirror_ddr_pll_lock_i, .mirror_ddr_pll_en_o,
    .mirror_ddr_pll_div_rst_n_o, .ddr_clock_generator_rate_o, .mirror_clk_rate_o, .cpu_rst_n_o,
    .cpu_clk_full_o, .normal_mode_o, .mirror_park_o, .boot_done_i, .low_power_req_i,
    .dcg_rate_i, .mirror_rate_i, .rst_release_i, .mirror_data_i, .mirror_oe_i, .gpio_out_i,
    .gpio_dir_i, .gpio_rd_o, .memtest_fail_o, .fl_req_i, .fl_sel_i, .fl_wait_i, .fl_addr_hi_i,
    .addr_pin_en_i, .fl_ack_o, .addr_pin_rd_o, .rst_out_n_o, .mirror_data_o,
    .mirror_drive_output_enable_o, .mirror_drive_output_enable_oe_o, .gpio_i, .gpio_o,
    .gpio_oe_o, .boot_flash_select_n_o, .optional_flash_select_n_o, .flash_select_oe_o,
    .flash_addr_bit21_pin_i, .flash_addr_bit21_pin_o, .flash_addr_bit21_pin_oe_o,
    .flash_addr_bit22_pin_i, .flash_addr_bit22_pin_o, .flash_addr_bit22_pin_oe_o);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // Nothing driven high, no clock or reset freed
  task automatic quiet();
    chk("quiet outputs", 0, {|gpio_oe_o, mirror_drive_output_enable_oe_o, flash_select_oe_o,
      flash_addr_bit21_pin_oe_o, flash_addr_bit22_pin_oe_o, |mirror_data_o, |rst_out_n_o,
      cpu_rst_n_o, master_pll_rst_n_o, mirror_ddr_pll_en_o});
  endtask

  // Reset state after any system reset
  task automatic reset_state();
    chk("gpio oe", 0, gpio_oe_o);
    chk("mirror pll", 0, {mirror_ddr_pll_en_o, mirror_ddr_pll_div_rst_n_o});
    chk("mirror pins", 0, {mirror_data_o, mirror_drive_output_enable_oe_o});
    chk("reset outs", 0, rst_out_n_o);
  endtask

  task automatic flash(input logic s, input logic [4:0] w, input int step);
    int k;
    @(posedge clk_i);
    fl_req_i <= 1'b1;
    fl_sel_i <= s;
    fl_wait_i <= w;
    @(posedge clk_i);
    fl_req_i <= 1'b0;
    @(negedge clk_i);
    k = 0;
    while ((s ? optional_flash_select_n_o : boot_flash_select_n_o) !== 1'b0 && k < 8) begin
      @(negedge clk_i);
      k++;
    end
    k = 0;
    while ((s ? optional_flash_select_n_o : boot_flash_select_n_o) === 1'b0 && k < 600) begin
      @(negedge clk_i);
      k++;
    end
    chk("select cycles", (w + 1) * step, k);
    chk("flash ack", 1, fl_ack_o);
    chk("other select", 1, s ? boot_flash_select_n_o : optional_flash_select_n_o);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    mirror_data_i = 24'($random(seed));
    mirror_oe_i = 1'($random(seed));
    gpio_out_i = $random(seed);
    gpio_i = $random(seed);
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    cyc(5);
    quiet();
    mon_u.sense_up(10);
    repeat (6) @(posedge clk_i);
    mon_u.sense_drop();
    mon_u.sense_up(0);
    n = 0;
    while (master_pll_rst_n_o !== 1'b1 && n < 10) begin
      @(negedge clk_i);
      n++;
    end
    n = 0;
    while (cpu_rst_n_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    chk("hold cycles", HOLD, n);
    mon_u.warn(4);
    cyc(1);
    chk("early warning", 2'b10, {cpu_rst_n_o, mirror_park_o});
    chk("full mode", 2'b11, {normal_mode_o, cpu_clk_full_o});
    reset_state();
    $display("Test power up done");
    exp_rst = 4'h0;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      rst_release_i <= 4'h1 << i;
      exp_rst = exp_rst | (4'h1 << i);
      @(posedge clk_i);
      rst_release_i <= 4'h0;
      cyc(2);
      chk("released", exp_rst, rst_out_n_o);
    end
    flash(1'b0, 5'h0, `PRS_WS_NORM_CYC);
    flash(1'b1, 5'h1f, `PRS_WS_NORM_CYC);
    flash(1'b0, 5'($random(seed)), `PRS_WS_NORM_CYC);
    $display("Test flash done");
    @(posedge clk_i);
    dcg_rate_i <= 4'($random(seed));
    mirror_rate_i <= 4'($random(seed));
    boot_done_i <= 1'b1;
    @(posedge clk_i);
    boot_done_i <= 1'b0;
    cyc(3);
    chk("pll on, dividers held", 2'b10,
      {mirror_ddr_pll_en_o, mirror_ddr_pll_div_rst_n_o});
    chk("dcg rate", dcg_rate_i, ddr_clock_generator_rate_o);
    @(posedge clk_i);
    mirror_ddr_pll_lock_i <= 1'b1;
    cyc(6);
    chk("dividers freed", 1, mirror_ddr_pll_div_rst_n_o);
    chk("mirror rate", mirror_rate_i, mirror_clk_rate_o);
    n = 0;
    while (gpio_o[26] !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    chk("init done", 3'b110, {gpio_o[26], gpio_oe_o[26], memtest_fail_o});
    cyc(1);
    chk("mirror pins", {1'b1, mirror_oe_i, mirror_data_i}, {mirror_drive_output_enable_oe_o,
      mirror_drive_output_enable_o, mirror_data_o});
    chk("gpio out", gpio_out_i & ~(32'h1 << 26), gpio_o & ~(32'h1 << 26));
    chk("gpio read", gpio_i, gpio_rd_o);
    $display("Test bring-up done");
    @(posedge clk_i);
    addr_pin_en_i <= 2'b01;
    fl_addr_hi_i <= 2'b11;
    cyc(3);
    chk("addr21 only", 3'b011, {flash_addr_bit22_pin_oe_o, flash_addr_bit21_pin_oe_o,
      flash_addr_bit21_pin_o});
    @(posedge clk_i);
    addr_pin_en_i <= 2'b11;
    fl_addr_hi_i <= 2'b10;
    cyc(5);
    chk("addr pins", 2'b10, {flash_addr_bit22_pin_o, flash_addr_bit21_pin_o});
    chk("addr read", 2'b10, addr_pin_rd_o);
    @(posedge clk_i);
    low_power_req_i <= 1'b1;
    cyc(3);
    // Wait count rounded up from a 90 ns part
    flash(1'b0, 5'((90000 + `PRS_WS_LP_PS - 1) / `PRS_WS_LP_PS), `PRS_WS_LP_CYC);
    $display("Test address and low power done");
    @(posedge clk_i);
    gpio_dir_i <= $random(seed) | 32'h1;
    cyc(3);
    fork
      mon_u.warn(20);
    join_none
    cyc(8);
    chk("warning reset", 3'b011, {cpu_rst_n_o, mirror_park_o, master_pll_rst_n_o});
    reset_state();
    n = 0;
    while (cpu_rst_n_o !== 1'b1 && n < 60) begin
      @(negedge clk_i);
      n++;
    end
    chk("back to full mode", 3'b111, {normal_mode_o, cpu_clk_full_o,
      master_pll_rst_n_o});
    $display("Test warning reset done");
    @(posedge clk_i);
    low_power_req_i <= 1'b0;
    gpio_dir_i <= 32'h0;
    mon_u.power_off();
    cyc(4);
    quiet();
    $display("Test power down done");
    end_of_test();
  end
endmodule // prs_sequencer_tb_top
